// ---- rtl/watchdog_power_sequencer.sv ----
// Watchdog and power sequencer for the radio module
`timescale 1ns/1ns
// Overview of operation
// - A timer of ten minutes runs from power-up or from the last kick.
// - On timeout the module gets a reset pulse and supervision restarts.
// - A kick pulse restarts the timeout count from zero.
// - The terminal powers on at supply and enters the network search state.
// - After an orderly power-off, terminal-ready activation powers it on.
// - After the shutdown notice, the module is off within one second.
// - Forced power-off removes all module supplies at once.
// - Temperature or voltage faults start an orderly shutdown.
// - Each temperature fault entry and exit raises an alert if enabled.
module watchdog_power_sequencer #(
  parameter logic [39:0] TIMEOUT_CYC = 40'(wdps_pkg::WDOG_TIMEOUT_CYC),
  parameter logic [39:0] SHUTDOWN_CYC = 40'(wdps_pkg::OFF_CYC)
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_watchdog_kick_pin,
  input wire logic i_term_ready,
  input wire logic i_forced_off,
  input wire logic i_temp_fault,
  input wire logic i_volt_fault,
  input wire logic i_poweroff_cmd,
  input wire logic i_search_done,
  input wire logic i_alert_en,
  output logic o_supply_on,
  output logic o_module_reset,
  output logic o_shutdown_notice,
  output logic o_powered_down,
  output logic o_temp_alert,
  output logic o_net_search
);

  // Every check below runs on this clock and rests while reset is low
  default clocking prop_clk @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Two-stage synchronisers for the pin inputs
  wdps_pkg::pins_s meta;
  wdps_pkg::pins_s sync;
  wdps_pkg::pins_s sync_d;
  wdps_pkg::pins_s raw;

  assign raw = '{kick: i_watchdog_kick_pin, term_ready: i_term_ready,
                 forced_off: i_forced_off, temp_fault: i_temp_fault,
                 volt_fault: i_volt_fault};

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta <= '0;
      sync <= '0;
      sync_d <= '0;
    end
    else
    begin
      meta <= raw;
      sync <= meta;
      sync_d <= sync;
    end
  end

  // Edge detection on synchronised levels only
  logic kick_rise;
  logic ready_rise;
  logic temp_edge;
  logic fault;
  assign kick_rise = sync.kick && !sync_d.kick;
  assign ready_rise = sync.term_ready && !sync_d.term_ready;
  assign temp_edge = sync.temp_fault != sync_d.temp_fault;
  assign fault = sync.temp_fault || sync.volt_fault;

  // Power state machine and counters
  wdps_pkg::pwr_state_e state;
  wdps_pkg::pwr_state_e next_state;
  logic [39:0] wd_cnt;
  logic [39:0] next_wd_cnt;
  logic [39:0] off_cnt;
  logic [39:0] next_off_cnt;
  logic [4:0] rst_cnt;
  logic [4:0] next_rst_cnt;
  wdps_pkg::pwr_s outs;
  wdps_pkg::pwr_s next_outs;
  logic net_search;
  logic next_net_search;

  always_comb
  begin
    next_state = state;
    next_wd_cnt = wd_cnt;
    next_off_cnt = off_cnt;
    next_rst_cnt = rst_cnt;
    next_outs = outs;
    next_outs.temp_alert = i_alert_en && temp_edge;
    next_outs.shutdown_notice = 1'b0;
    next_outs.module_reset = rst_cnt != 5'd0;
    if (rst_cnt != 5'd0)
    begin
      next_rst_cnt = rst_cnt - 5'd1;
    end
    case (state)
      wdps_pkg::ST_SEARCH, wdps_pkg::ST_ON:
      begin
        if (state == wdps_pkg::ST_SEARCH && i_search_done)
        begin
          next_state = wdps_pkg::ST_ON;
        end
        // Kick wins; a reset pulse also restarts supervision
        if (kick_rise || rst_cnt != 5'd0)
        begin
          next_wd_cnt = '0;
        end
        else if (wd_cnt >= TIMEOUT_CYC - 40'd1)
        begin
          next_wd_cnt = '0;
          next_rst_cnt = 5'(wdps_pkg::RST_PULSE_CYC);
          next_outs.module_reset = 1'b1;
          next_state = wdps_pkg::ST_SEARCH;
        end
        else
        begin
          next_wd_cnt = wd_cnt + 40'd1;
        end
        if (i_poweroff_cmd || fault)
        begin
          next_state = wdps_pkg::ST_SHUTDOWN;
          next_outs.shutdown_notice = 1'b1;
          next_off_cnt = '0;
        end
      end
      wdps_pkg::ST_SHUTDOWN:
      begin
        next_off_cnt = off_cnt + 40'd1;
        if (off_cnt >= SHUTDOWN_CYC - 40'd1)
        begin
          next_state = wdps_pkg::ST_DOWN;
          next_outs.supply_on = 1'b0;
          next_outs.powered_down = 1'b1;
        end
      end
      wdps_pkg::ST_DOWN:
      begin
        // Fault must clear first or the wake would bounce straight off
        if (ready_rise && !fault)
        begin
          next_state = wdps_pkg::ST_SEARCH;
          next_outs.supply_on = 1'b1;
          next_outs.powered_down = 1'b0;
          next_wd_cnt = '0;
        end
      end
      default:
      begin
        next_state = wdps_pkg::ST_DOWN;
      end
    endcase
    // Forced off overrides the state and the power and reset outputs, no orderly phase; temperature alerts still pass
    if (sync.forced_off)
    begin
      next_state = wdps_pkg::ST_DOWN;
      next_outs.supply_on = 1'b0;
      next_outs.powered_down = 1'b1;
      next_outs.shutdown_notice = 1'b0;
      next_outs.module_reset = 1'b0;
      next_rst_cnt = '0;
    end
    next_net_search = next_state == wdps_pkg::ST_SEARCH;
  end

  // Registers; reset means supply present, so power on into search
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= wdps_pkg::ST_SEARCH;
      wd_cnt <= '0;
      off_cnt <= '0;
      rst_cnt <= '0;
      outs <= '{supply_on: 1'b1, module_reset: 1'b0, shutdown_notice: 1'b0,
                powered_down: 1'b0, temp_alert: 1'b0};
      net_search <= 1'b1;
    end
    else
    begin
      state <= next_state;
      wd_cnt <= next_wd_cnt;
      off_cnt <= next_off_cnt;
      rst_cnt <= next_rst_cnt;
      outs <= next_outs;
      net_search <= next_net_search;
    end
  end

  assign o_supply_on = outs.supply_on;
  assign o_module_reset = outs.module_reset;
  assign o_shutdown_notice = outs.shutdown_notice;
  assign o_powered_down = outs.powered_down;
  assign o_temp_alert = outs.temp_alert;
  assign o_net_search = net_search;

  // Checks
  logic running;
  assign running = state == wdps_pkg::ST_SEARCH || state == wdps_pkg::ST_ON;

  AST_KICK_CLEARS: assert property (
    running && kick_rise && !sync.forced_off && !i_poweroff_cmd && !fault
    |=> wd_cnt == 40'h0)
    else $error("kick did not clear watchdog count");
  AST_TIMEOUT_RESET: assert property (
    running && !kick_rise && rst_cnt == 5'h0 && !sync.forced_off
    && wd_cnt == TIMEOUT_CYC - 40'h1 |=> o_module_reset && wd_cnt == 40'h0)
    else $error("timeout did not reset module");
  AST_COUNT_UP: assert property (
    running && !kick_rise && rst_cnt == 5'h0 && !sync.forced_off
    && !i_poweroff_cmd && !fault && wd_cnt < TIMEOUT_CYC - 40'h1
    |=> wd_cnt == $past(wd_cnt) + 40'h1)
    else $error("watchdog count did not advance");
  AST_FORCED_OFF: assert property (
    sync.forced_off |=> !o_supply_on && o_powered_down)
    else $error("forced off did not cut supply");
  AST_SHUTDOWN_END: assert property (
    state == wdps_pkg::ST_SHUTDOWN && off_cnt == SHUTDOWN_CYC - 40'h1
    |=> o_powered_down && !o_supply_on)
    else $error("shutdown overran its limit");
  AST_FAULT_SHUTS: assert property (
    running && fault && !sync.forced_off
    |=> state == wdps_pkg::ST_SHUTDOWN && o_shutdown_notice)
    else $error("fault did not start shutdown");
  AST_WAKE: assert property (
    state == wdps_pkg::ST_DOWN && ready_rise && !fault && !sync.forced_off
    |=> o_supply_on && o_net_search)
    else $error("terminal-ready did not wake");
  // A wake while a limit is still broken would only bounce off again
  AST_NO_WAKE_IN_FAULT: assert property (
    state == wdps_pkg::ST_DOWN && fault |=> state == wdps_pkg::ST_DOWN)
    else $error("woke while a fault was present");
  AST_ALERT: assert property (
    temp_edge |=> o_temp_alert == $past(i_alert_en))
    else $error("temperature alert wrong");
  AST_NO_ALERT: assert property (
    !temp_edge |=> !o_temp_alert)
    else $error("alert without a temperature edge");
  // A level held high must not keep restarting the count
  AST_HELD_KICK: assert property (
    running && sync_d.kick && rst_cnt == 5'h0 && !sync.forced_off
    && wd_cnt < TIMEOUT_CYC - 40'h1 |=> wd_cnt == $past(wd_cnt) + 40'h1)
    else $error("held kick counted twice");

  COV_KICK: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    running && kick_rise);
  COV_TIMEOUT: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_module_reset));
  COV_SHUTDOWN: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    o_shutdown_notice ##[1:300] o_powered_down);
  COV_WAKE: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    state == wdps_pkg::ST_DOWN && ready_rise);

endmodule

// ---- rtl/wdps_pkg.sv ----
// Package: timing constants, states and carrier structs for the supervisor
package wdps_pkg;

  // Clock rate
  localparam longint unsigned CLK_HZ = 64'd125_000_000;

  // Watchdog timeout in minutes
  localparam longint unsigned WDOG_TIMEOUT_MIN = 64'd10;
  localparam longint unsigned WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MIN * 64'd60 * CLK_HZ;

  // Longest time from shutdown notice to power down, in ms (rounded down)
  localparam longint unsigned OFF_MAX_MS = 64'd1000;
  localparam longint unsigned OFF_CYC = OFF_MAX_MS * CLK_HZ / 64'd1000;

  // Width of the long counters
  localparam int unsigned CNT_W = 40;

  // Module reset pulse length in cycles, less one (the pulse lasts this count plus one)
  localparam int unsigned RST_PULSE_CYC = 16;

  // Power states, one-hot
  typedef enum logic [3:0] {
    ST_SEARCH = 4'b0001,
    ST_ON = 4'b0010,
    ST_SHUTDOWN = 4'b0100,
    ST_DOWN = 4'b1000
  } pwr_state_e;

  // Pin inputs after synchronisation
  typedef struct packed {
    logic kick;
    logic term_ready;
    logic forced_off;
    logic temp_fault;
    logic volt_fault;
  } pins_s;

  // Power outputs
  typedef struct packed {
    logic supply_on;
    logic module_reset;
    logic shutdown_notice;
    logic powered_down;
    logic temp_alert;
  } pwr_s;

endpackage

// ---- bench/app_kicker.sv ----
// Model of the module application that kicks the watchdog
`timescale 1ns/1ns
module app_kicker #(
  parameter int PERIOD = 400
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  output logic o_kick
);
  int cnt;
  // Four-cycle pulse every PERIOD cycles, well inside the timeout
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt <= 0;
      o_kick <= 1'b0;
    end
    else
    begin
      cnt <= (i_enable && cnt < PERIOD - 1) ? cnt + 1 : 0;
      o_kick <= i_enable && cnt < 4;
    end
  end
endmodule

// ---- bench/watchdog_power_sequencer_test.sv ----
// Self-checking bench for the watchdog and power sequencer
`timescale 1ns/1ns
module watchdog_power_sequencer_test;
  localparam int TO = 1000;
  localparam int SD = 50;
  logic i_clk, i_arst_n, kick_en, hold, kicker, term_ready, forced_off;
  logic temp_fault, volt_fault, poweroff_cmd, alert_en, rst_seen, search_done;
  logic supply_on, module_reset, notice, powered_down, temp_alert, net_search;
  int n_fail, checked, cyc, t, n_alert;

  app_kicker app_kicker_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_enable(kick_en), .o_kick(kicker));
  watchdog_power_sequencer #(.TIMEOUT_CYC(40'(TO)), .SHUTDOWN_CYC(40'(SD)))
    watchdog_power_sequencer_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_watchdog_kick_pin(kicker | hold), .i_term_ready(term_ready),
    .i_forced_off(forced_off), .i_temp_fault(temp_fault),
    .i_volt_fault(volt_fault), .i_poweroff_cmd(poweroff_cmd),
    .i_search_done(search_done), .i_alert_en(alert_en),
    .o_supply_on(supply_on),
    .o_module_reset(module_reset), .o_shutdown_notice(notice),
    .o_powered_down(powered_down), .o_temp_alert(temp_alert),
    .o_net_search(net_search));

  // Clock, watchdog of the run itself, event monitors
  initial
  begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    n_alert <= n_alert + int'(temp_alert === 1'b1);
    if (module_reset === 1'b1)
      rst_seen <= 1'b1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  // Bounded wait for a high level; w is cycles waited
  task automatic await(ref logic s, input int n, output int w);
    w = 0;
    while (s !== 1'b1 && w <= n)
    begin
      @(posedge i_clk);
      #1;
      w++;
    end
  endtask

  // Search ends on the done strobe, leaving the search state
  task automatic t_search();
    @(posedge i_clk);
    search_done <= 1'b1;
    @(posedge i_clk);
    search_done <= 1'b0;
    #1;
    chk("search ends", 1'b0, net_search);
  endtask

  // Kicks from the model keep the module out of reset
  task automatic t_kicks();
    rst_seen = 1'b0;
    @(posedge i_clk);
    kick_en <= 1'b1;
    repeat (3 * TO) @(posedge i_clk);
    kick_en <= 1'b0;
    chk("reset while kicked", 1'b0, rst_seen);
  endtask

  // Held-high pin kicks once; two timeouts follow it
  task automatic t_timeout();
    repeat (10) @(posedge i_clk);
    hold <= 1'b1;
    await(module_reset, TO + 10, t);
    chk("first timeout not early", 1'b1, t >= TO);
    chk("first timeout on time", 1'b1, t <= TO + 5);
    chk("search after reset", 1'b1, net_search);
    repeat (20) @(posedge i_clk);
    #1;
    await(module_reset, TO + 10, t);
    chk("held kick counted once", 1'b1, t <= TO);
    @(posedge i_clk);
    hold <= 1'b0;
  endtask

  task automatic wake();
    repeat (5) @(posedge i_clk);
    term_ready <= 1'b1;
    await(supply_on, 8, t);
    chk("wake supply", 1'b1, t <= 6);
    chk("wake search", 1'b1, net_search);
    @(posedge i_clk);
    term_ready <= 1'b0;
  endtask

  // Power-off command: notice next edge, down within the limit, wake
  task automatic t_poweroff();
    @(posedge i_clk);
    poweroff_cmd <= 1'b1;
    @(posedge i_clk);
    poweroff_cmd <= 1'b0;
    #1;
    chk("notice", 1'b1, notice);
    await(powered_down, SD + 5, t);
    chk("down in time", 1'b1, t <= SD + 1);
    chk("supply off", 1'b0, supply_on);
    wake();
  endtask

  // Temperature or voltage fault, as temp selects; alerts on temperature edges
  task automatic t_fault(input bit temp);
    int base;
    @(posedge i_clk);
    // Snapshot instead of clearing: the monitor owns the counter
    base = n_alert;
    alert_en <= 1'b1;
    temp_fault <= temp;
    volt_fault <= !temp;
    await(notice, 8, t);
    chk("fault notice", 1'b1, t <= 5);
    await(powered_down, SD + 5, t);
    chk("fault down", 1'b1, t <= SD + 1);
    // Wake attempt while the limit is still broken
    @(posedge i_clk);
    term_ready <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("no wake in fault", 1'b0, supply_on);
    term_ready <= 1'b0;
    temp_fault <= 1'b0;
    volt_fault <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("alert count", 1'b1, n_alert - base == (temp ? 2 : 0));
    wake();
  endtask

  // Orderly off, host waits out the limit, then cycles the supply
  task automatic t_supply();
    @(posedge i_clk);
    poweroff_cmd <= 1'b1;
    @(posedge i_clk);
    poweroff_cmd <= 1'b0;
    repeat (SD + 2) @(posedge i_clk);
    chk("down before supply cut", 1'b1, powered_down);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    #1;
    chk("supply after restore", 1'b1, supply_on);
    chk("search after restore", 1'b1, net_search);
    chk("up after restore", 1'b0, powered_down);
  endtask

  // Forced power-off cuts supply at once, with no orderly phase
  task automatic t_forced();
    @(posedge i_clk);
    forced_off <= 1'b1;
    await(powered_down, 8, t);
    chk("forced down", 1'b1, t <= 5);
    chk("forced supply", 1'b0, supply_on);
  endtask

  initial
  begin
    {i_arst_n, kick_en, hold, term_ready, forced_off, search_done} = '0;
    {temp_fault, volt_fault, poweroff_cmd, alert_en, rst_seen} = '0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    #1;
    chk("reset supply", 1'b1, supply_on);
    chk("reset search", 1'b1, net_search);
    // Host reads nothing back in the settle window after start-up
    repeat (2) @(posedge i_clk);
    t_search();
    t_kicks();
    t_timeout();
    t_poweroff();
    t_fault(1'b1);
    t_fault(1'b0);
    t_supply();
    t_forced();
    results();
  end
endmodule
